// file: rtl/wkev_pkg.sv
package wkev_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] WKEV_IRQ_STS_ADDR  = 12'h058;
  localparam logic [ADDR_W-1:0] WKEV_IRQ_MASK_ADDR = 12'h05C;
  localparam logic [ADDR_W-1:0] WKEV_HWCFG_ADDR    = 12'h074;
  localparam logic [ADDR_W-1:0] WKEV_PMC_ADDR      = 12'h084;

  // Field positions of the power management control register.
  localparam int PMC_LWEN_BIT = 9;
  localparam int PMC_TYPE_BIT = 6;
  localparam int PMC_STS_BIT  = 5;
  localparam int PMC_IND_BIT  = 3;
  localparam int PMC_POL_BIT  = 2;
  localparam int PMC_PEN_BIT  = 1;
  localparam int PMC_RDY_BIT  = 0;

  // Reserved bits of the power management control register.
  localparam logic [DATA_W-1:0] PMC_RSV_MASK = 32'h0000_0190;

  // Ready mirror in the hardware configuration register.
  localparam int HWCFG_RDY_BIT = 27;

  // Interrupt status and mask layout.
  localparam int IRQ_W        = 2;
  localparam int IRQ_RDY_BIT  = 0;
  localparam int IRQ_WAKE_BIT = 1;

  // Reset values.
  localparam logic [IRQ_W-1:0]  IRQ_RST  = 2'h0;
  localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;

  // Timing.
  localparam int CLK_MHZ          = 200;
  localparam int PULSE_MS         = 50;
  localparam int PULSE_CYCLES_DEF = PULSE_MS * 1000 * CLK_MHZ;
  localparam int READY_CYCLES_DEF = 64;

  // Indication style encoding.
  localparam logic STYLE_PULSE = 1'b0;
  localparam logic STYLE_HOLD  = 1'b1;

  typedef struct packed {
    logic lan_wake_enable;
    logic driver_type;
    logic polarity;
    logic style;
    logic pin_enable;
  } wkev_cfg_type;

  localparam wkev_cfg_type CFG_RST = '{default: 1'b0};

  typedef enum logic [1:0] {
    WKEV_IDLE  = 2'b00,
    WKEV_PULSE = 2'b01,
    WKEV_HOLD  = 2'b10,
    WKEV_DONE  = 2'b11
  } wkev_pin_state_type;

endpackage

// file: rtl/wkev_pulse_timer.sv
`timescale 1ns/1ps
module wkev_pulse_timer
#(
  parameter int CNT_W  = 24,
  parameter int CYCLES = 10000000
)
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic start,
  input  wire logic abort,
  output logic      done
);

  import wkev_pkg::*;

  initial
  begin
    if (CYCLES < 1 || CYCLES >= (2 ** CNT_W))
    begin
      $error("wkev_pulse_timer: CYCLES does not fit CNT_W");
    end
  end

  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES - 1);
  localparam logic [CNT_W-1:0] ZERO = '0;

  logic [CNT_W-1:0] cnt_r;
  logic             run_r;

  ////////////////////////////////////////////////////////////////////////////
  // Counts down one pulse length; done is a single-cycle pulse at the end.

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r <= ZERO;
      run_r <= 1'b0;
    end
    else if (abort)
    begin
      cnt_r <= ZERO;
      run_r <= 1'b0;
    end
    else if (start)
    begin
      cnt_r <= LOAD;
      run_r <= 1'b1;
    end
    else if (run_r && cnt_r == ZERO)
    begin
      run_r <= 1'b0;
    end
    else if (run_r)
    begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign done = run_r && (cnt_r == ZERO) && !abort;

endmodule

// file: rtl/wkev_ctrl.sv
`timescale 1ns/1ps
module wkev_ctrl
  import wkev_pkg::*;
#(
  parameter int PULSE_CYCLES = wkev_pkg::PULSE_CYCLES_DEF,
  parameter int PULSE_CNT_W  = 24,
  parameter int READY_CYCLES = wkev_pkg::READY_CYCLES_DEF,
  parameter int READY_CNT_W  = 16
)
(
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        soft_reset,
  input  wire logic                        digital_reset,
  input  wire logic [wkev_pkg::ADDR_W-1:0] addr,
  input  wire logic [wkev_pkg::DATA_W-1:0] wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output logic      [wkev_pkg::DATA_W-1:0] rdata,
  input  wire logic                        lan_wake_event,
  input  wire logic                        mac_event_pending,
  output logic                             wake_event_out,
  output logic                             wake_event_oe_n,
  output logic                             ready,
  output logic                             irq
);

  import wkev_pkg::*;

  initial
  begin
    if (READY_CYCLES < 1 || READY_CYCLES >= (2 ** READY_CNT_W))
    begin
      $error("wkev_ctrl: READY_CYCLES does not fit READY_CNT_W");
    end
  end

  localparam logic [READY_CNT_W-1:0] READY_LAST = READY_CNT_W'(READY_CYCLES);

  wkev_cfg_type             cfg_r;
  logic                     lan_wake_status_r;
  logic                     ready_r;
  logic [READY_CNT_W-1:0]   rdy_cnt_r;
  logic [IRQ_W-1:0]         irq_sts_r;
  logic [IRQ_W-1:0]         irq_mask_r;
  logic [DATA_W-1:0]        rdata_r;
  logic                     wake_out_r;
  logic                     wake_oe_n_r;
  wkev_pin_state_type       state_r;
  wkev_pin_state_type       state_nxt;
  logic                     sys_clr;
  logic                     wr_pmc;
  logic                     rd_irq;
  logic                     ready_rise;
  logic                     wake_cause;
  logic                     pin_active;
  logic                     pulse_start;
  logic                     pulse_done;
  logic                     irq_wake_set;

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  function automatic logic [DATA_W-1:0] pmc_word(input wkev_cfg_type c,
                                                 input logic sts,
                                                 input logic rdy);
    logic [DATA_W-1:0] w;
    w = WORD_RST;
    w[PMC_LWEN_BIT] = c.lan_wake_enable;
    w[PMC_TYPE_BIT] = c.driver_type;
    w[PMC_STS_BIT]  = sts;
    w[PMC_IND_BIT]  = c.style;
    w[PMC_POL_BIT]  = c.polarity;
    w[PMC_PEN_BIT]  = c.pin_enable;
    w[PMC_RDY_BIT]  = rdy;
    pmc_word = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  assign sys_clr = soft_reset || digital_reset;
  assign wr_pmc  = wr && hit(addr, WKEV_PMC_ADDR);
  assign rd_irq  = rd && hit(addr, WKEV_IRQ_STS_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields; type and polarity survive soft reset.

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_r <= CFG_RST;
    end
    else if (digital_reset)
    begin
      cfg_r <= CFG_RST;
    end
    else if (soft_reset)
    begin
      cfg_r.lan_wake_enable <= CFG_RST.lan_wake_enable;
      cfg_r.style           <= CFG_RST.style;
      cfg_r.pin_enable      <= CFG_RST.pin_enable;
    end
    else if (wr_pmc)
    begin
      cfg_r.lan_wake_enable <= wdata[PMC_LWEN_BIT];
      cfg_r.driver_type     <= wdata[PMC_TYPE_BIT];
      cfg_r.style           <= wdata[PMC_IND_BIT];
      cfg_r.polarity        <= wdata[PMC_POL_BIT];
      cfg_r.pin_enable      <= wdata[PMC_PEN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake status: set wins over a write clear.

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lan_wake_status_r <= 1'b0;
    end
    else if (lan_wake_event)
    begin
      lan_wake_status_r <= 1'b1;
    end
    else if (sys_clr)
    begin
      lan_wake_status_r <= 1'b0;
    end
    else if (wr_pmc && wdata[PMC_STS_BIT] && !mac_event_pending)
    begin
      lan_wake_status_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready flag after a settling delay.

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdy_cnt_r <= '0;
      ready_r   <= 1'b0;
    end
    else if (sys_clr)
    begin
      rdy_cnt_r <= '0;
      ready_r   <= 1'b0;
    end
    else if (rdy_cnt_r == READY_LAST)
    begin
      ready_r <= 1'b1;
    end
    else
    begin
      rdy_cnt_r <= rdy_cnt_r + 1'b1;
    end
  end

  assign ready      = ready_r;
  assign ready_rise = !ready_r && !sys_clr && (rdy_cnt_r == READY_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, cleared by read; a new event wins over the clear.

  assign irq_wake_set = lan_wake_event && cfg_r.lan_wake_enable;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_sts_r <= IRQ_RST;
    end
    else if (sys_clr)
    begin
      irq_sts_r <= IRQ_RST;
    end
    else
    begin
      if (ready_rise)
      begin
        irq_sts_r[IRQ_RDY_BIT] <= 1'b1;
      end
      else if (rd_irq)
      begin
        irq_sts_r[IRQ_RDY_BIT] <= 1'b0;
      end
      if (irq_wake_set)
      begin
        irq_sts_r[IRQ_WAKE_BIT] <= 1'b1;
      end
      else if (rd_irq)
      begin
        irq_sts_r[IRQ_WAKE_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_mask_r <= IRQ_RST;
    end
    else if (sys_clr)
    begin
      irq_mask_r <= IRQ_RST;
    end
    else if (wr && hit(addr, WKEV_IRQ_MASK_ADDR))
    begin
      irq_mask_r <= wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_sts_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe.

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_r <= WORD_RST;
    end
    else if (!rd)
    begin
      rdata_r <= WORD_RST;
    end
    else if (hit(addr, WKEV_PMC_ADDR))
    begin
      rdata_r <= pmc_word(cfg_r, lan_wake_status_r, ready_r);
    end
    else if (hit(addr, WKEV_HWCFG_ADDR))
    begin
      rdata_r                <= WORD_RST;
      rdata_r[HWCFG_RDY_BIT] <= ready_r;
    end
    else if (hit(addr, WKEV_IRQ_STS_ADDR))
    begin
      rdata_r <= {{(DATA_W-IRQ_W){1'b0}}, irq_sts_r};
    end
    else if (hit(addr, WKEV_IRQ_MASK_ADDR))
    begin
      rdata_r <= {{(DATA_W-IRQ_W){1'b0}}, irq_mask_r};
    end
    else
    begin
      rdata_r <= WORD_RST;
    end
  end

  assign rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Indication state machine.

  assign wake_cause = cfg_r.lan_wake_enable && lan_wake_status_r;

  always_comb
  begin
    state_nxt   = state_r;
    pulse_start = 1'b0;
    case (state_r)
      WKEV_IDLE:
      begin
        if (wake_cause && cfg_r.style == STYLE_PULSE)
        begin
          state_nxt   = WKEV_PULSE;
          pulse_start = 1'b1;
        end
        else if (wake_cause)
        begin
          state_nxt = WKEV_HOLD;
        end
      end
      WKEV_PULSE:
      begin
        if (!wake_cause)
        begin
          state_nxt = WKEV_IDLE;
        end
        else if (pulse_done)
        begin
          state_nxt = WKEV_DONE;
        end
      end
      WKEV_HOLD:
      begin
        if (!wake_cause)
        begin
          state_nxt = WKEV_IDLE;
        end
      end
      WKEV_DONE:
      begin
        if (!wake_cause)
        begin
          state_nxt = WKEV_IDLE;
        end
      end
      default:
      begin
        state_nxt = WKEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= WKEV_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  wkev_pulse_timer
  #(
    .CNT_W  (PULSE_CNT_W),
    .CYCLES (PULSE_CYCLES)
  )
  u_pulse
  (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (pulse_start),
    .abort   (state_r == WKEV_PULSE && !wake_cause),
    .done    (pulse_done)
  );

  assign pin_active = wake_cause && cfg_r.pin_enable &&
                      (state_r == WKEV_PULSE || state_r == WKEV_HOLD);

  ////////////////////////////////////////////////////////////////////////////
  // Pin driver.

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wake_out_r  <= 1'b0;
      wake_oe_n_r <= 1'b1;
    end
    else if (cfg_r.driver_type)
    begin
      wake_oe_n_r <= 1'b0;
      wake_out_r  <= pin_active ? cfg_r.polarity : !cfg_r.polarity;
    end
    else
    begin
      wake_oe_n_r <= !pin_active;
      wake_out_r  <= 1'b0;
    end
  end

  assign wake_event_out  = wake_out_r;
  assign wake_event_oe_n = wake_oe_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence wr_clr_s;
    wr_pmc && wdata[PMC_STS_BIT] && !lan_wake_event && !sys_clr;
  endsequence

  sequence od_drive_s;
    !cfg_r.driver_type && pin_active;
  endsequence

  od_low_a: assert property (od_drive_s |=> !wake_event_oe_n && !wake_event_out)
    else $error("open-drain pin not driven low");
  od_release_a: assert property (!wake_event_oe_n && !$past(cfg_r.driver_type) |-> !wake_event_out)
    else $error("open-drain pin driven high");
  pp_level_a: assert property (cfg_r.driver_type && pin_active |=> !wake_event_oe_n && wake_event_out == $past(cfg_r.polarity))
    else $error("push-pull active level wrong");
  sts_set_a: assert property (lan_wake_event |=> lan_wake_status_r)
    else $error("wake status not set");
  sts_hold_a: assert property (wr_clr_s and mac_event_pending |=> lan_wake_status_r == $past(lan_wake_status_r))
    else $error("status cleared while MAC event pending");
  sts_clr_a: assert property (wr_clr_s and !mac_event_pending |=> !lan_wake_status_r ##1 !pin_active)
    else $error("status clear did not drop pin");
  pin_gate_a: assert property (!cfg_r.pin_enable |-> !pin_active)
    else $error("pin active while disabled");
  irq_indep_a: assert property (lan_wake_event && cfg_r.lan_wake_enable && !sys_clr |=> irq_sts_r[IRQ_WAKE_BIT])
    else $error("wake interrupt status not set");
  ready_mirror_a: assert property (rd && hit(addr, WKEV_HWCFG_ADDR) |=> rdata[HWCFG_RDY_BIT] == $past(ready_r))
    else $error("ready mirror differs");
  ready_irq_a: assert property ($rose(ready_r) |-> irq_sts_r[IRQ_RDY_BIT])
    else $error("ready interrupt status missing");
  ready_clr_a: assert property (sys_clr |=> !ready_r [*2])
    else $error("ready not cleared by reset");
  soft_reset_immune_keep_a: assert property (soft_reset && !digital_reset |=> $stable(cfg_r.driver_type) && $stable(cfg_r.polarity))
    else $error("soft reset changed driver type or polarity");
  rsv_zero_a: assert property (rd && hit(addr, WKEV_PMC_ADDR) |=> (rdata & PMC_RSV_MASK) == WORD_RST)
    else $error("reserved bits not zero");
  hold_style_a: assert property (state_r == WKEV_IDLE && wake_cause && cfg_r.style == STYLE_HOLD |=> state_r == WKEV_HOLD)
    else $error("continuous indication not entered");

endmodule

// file: tb/wkev_mac_model.sv
`timescale 1ns/1ps
// Host MAC wake source and the board pull-up on the wake pin.
module wkev_mac_model
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic fire,
  input  wire logic release_evt,
  input  wire logic wake_event_out,
  input  wire logic wake_event_oe_n,
  output logic      lan_wake_event,
  output logic      mac_event_pending,
  output logic      pin_level
);
  ////////////////////////////////////////
  // One detection pulse for each wake frame.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      lan_wake_event <= 1'b0;
    else
      lan_wake_event <= fire;
  end

  // The MAC keeps its own event until the host releases it.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      mac_event_pending <= 1'b0;
    else if (fire)
      mac_event_pending <= 1'b1;
    else if (release_evt)
      mac_event_pending <= 1'b0;
  end

  // An undriven pin is pulled high by the board.
  assign pin_level = wake_event_oe_n ? 1'b1 : wake_event_out;
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import wkev_pkg::*;
  localparam int PC = 20;
  localparam int RC = 4;
  localparam logic [ADDR_W-1:0] PA  = WKEV_PMC_ADDR;
  localparam logic [ADDR_W-1:0] SA  = WKEV_IRQ_STS_ADDR;
  localparam logic [DATA_W-1:0] RDY = 32'h0000_0001;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] v;
  logic              clk;
  logic              reset_n;
  logic              soft_reset;
  logic              digital_reset;
  logic              wr;
  logic              rd;
  logic              fire;
  logic              release_evt;
  logic              lan_wake_event;
  logic              mac_event_pending;
  logic              wake_event_out;
  logic              wake_event_oe_n;
  logic              ready;
  logic              irq;
  logic              pin_level;
  logic              pol;
  int                miscompares;
  int                n_compared;
  int                cnt;

  wkev_ctrl #(.PULSE_CYCLES(PC), .PULSE_CNT_W(8), .READY_CYCLES(RC),
    .READY_CNT_W(4)) wkev_ctrl_i (.clk(clk), .reset_n(reset_n),
    .soft_reset(soft_reset), .digital_reset(digital_reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .lan_wake_event(lan_wake_event), .mac_event_pending(mac_event_pending),
    .wake_event_out(wake_event_out), .wake_event_oe_n(wake_event_oe_n),
    .ready(ready), .irq(irq));

  wkev_mac_model wkev_mac_model_i (.clk(clk), .reset_n(reset_n),
    .fire(fire), .release_evt(release_evt), .wake_event_out(wake_event_out),
    .wake_event_oe_n(wake_event_oe_n), .lan_wake_event(lan_wake_event),
    .mac_event_pending(mac_event_pending), .pin_level(pin_level));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, e, rdata);
  endtask

  task automatic mac(input logic f, input logic r);
    @(posedge clk);
    fire <= f;
    release_evt <= r;
    @(posedge clk);
    fire <= 1'b0;
    release_evt <= 1'b0;
  endtask

  task automatic wait_ready();
    cnt = 0;
    while (ready !== 1'b1 && cnt < 50)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    chk("ready", 32'h1, {31'h0, ready});
    if (ready !== 1'b1)
      results();
  endtask

  task automatic wait_pin(input string what, input logic [1:0] e);
    #1;
    cnt = 0;
    while ({wake_event_oe_n, wake_event_out} !== e && cnt < 8)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    chk(what, {30'h0, e}, {30'h0, wake_event_oe_n, wake_event_out});
    if ({wake_event_oe_n, wake_event_out} !== e)
      results();
  endtask

  function automatic logic [1:0] pin_exp(input logic ty, input logic pl,
                                         input logic act);
    if (!ty)
      return act ? 2'b00 : 2'b10;
    return {1'b0, act ? pl : ~pl};
  endfunction

  function automatic logic [31:0] pmc(input logic en, input logic ty,
                                      input logic st, input logic pl,
                                      input logic pe);
    return (32'(en) << PMC_LWEN_BIT) | (32'(ty) << PMC_TYPE_BIT)
         | (32'(st) << PMC_IND_BIT) | (32'(pl) << PMC_POL_BIT)
         | (32'(pe) << PMC_PEN_BIT);
  endfunction

  ////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge clk);
    miscompares++;
    results();
  end

  initial
  begin
    {reset_n, soft_reset, digital_reset, wr, rd, fire, release_evt} = '0;
    addr = '0;
    wdata = '0;
    miscompares = 0;
    n_compared = 0;
    void'($urandom(40));
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rchk("pmc early", PA, 32'h0);
    wait_ready();
    rchk("pmc ready", PA, RDY);
    rchk("hwcfg", WKEV_HWCFG_ADDR, RDY << HWCFG_RDY_BIT);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr_reg(WKEV_IRQ_MASK_ADDR, 32'h3);
    #1;
    chk("irq ready", 32'h1, {31'h0, irq});
    rchk("irq sts ready", SA, 32'h1);
    #1;
    chk("irq clear", 32'h0, {31'h0, irq});
    for (int i = 0; i < 4; i++)
    begin
      v = $urandom;
      wr_reg(PA, v);
      rchk("pmc rw", PA, (v & 32'h0000_024E) | RDY);
    end
    wr_reg(12'h100, $urandom);
    rchk("unmapped", 12'h100, 32'h0);
    $display("test registers done");
    for (int t = 0; t < 2; t++)
    begin
      pol = 1'($urandom);
      v = pmc(1'b1, 1'(t), STYLE_HOLD, pol, 1'b1);
      wr_reg(PA, v);
      wait_pin("pin idle", pin_exp(1'(t), pol, 1'b0));
      mac(1'b1, 1'b0);
      wait_pin("pin active", pin_exp(1'(t), pol, 1'b1));
      chk("wire", {31'h0, t ? pol : 1'b0}, {31'h0, pin_level});
      rchk("wake sts", PA, v | 32'h21);
      chk("irq wake", 32'h1, {31'h0, irq});
      rchk("irq sts wake", SA, 32'h2);
      wr_reg(PA, v | 32'h20);
      rchk("sts kept", PA, v | 32'h21);
      wait_pin("pin kept", pin_exp(1'(t), pol, 1'b1));
      mac(1'b0, 1'b1);
      wr_reg(PA, v | 32'h20);
      wait_pin("pin drop", pin_exp(1'(t), pol, 1'b0));
      rchk("sts clear", PA, v | RDY);
    end
    $display("test pin modes done");
    v = pmc(1'b1, 1'b1, STYLE_PULSE, 1'b1, 1'b1);
    wr_reg(PA, v);
    mac(1'b1, 1'b0);
    wait_pin("pulse on", 2'b01);
    cnt = 0;
    while (wake_event_out === 1'b1 && cnt < 200)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    chk("pulse length", PC, cnt);
    if (cnt >= 200)
      results();
    wait_pin("pulse off", 2'b00);
    rchk("sts after pulse", PA, v | 32'h21);
    mac(1'b0, 1'b1);
    wr_reg(PA, v | 32'h20);
    rchk("irq sts pulse", SA, 32'h2);
    $display("test pulse done");
    v = pmc(1'b1, 1'b1, STYLE_HOLD, 1'b1, 1'b0);
    wr_reg(PA, v);
    mac(1'b1, 1'b0);
    repeat (6) @(posedge clk);
    #1;
    chk("pin gated", 32'h0, {30'h0, wake_event_oe_n, wake_event_out});
    rchk("irq sts gated", SA, 32'h2);
    wr_reg(PA, v | 32'h2);
    wait_pin("pin enabled", 2'b01);
    wr_reg(PA, v & ~32'h200 | 32'h2);
    wait_pin("enable drop", 2'b00);
    mac(1'b0, 1'b1);
    wr_reg(PA, v | 32'h20);
    $display("test pin enable done");
    wr_reg(PA, pmc(1'b1, 1'b1, STYLE_HOLD, 1'b1, 1'b1));
    @(posedge clk);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    rchk("soft keep", PA, 32'h0000_0044);
    wait_ready();
    rchk("soft ready", PA, 32'h0000_0045);
    @(posedge clk);
    digital_reset <= 1'b1;
    @(posedge clk);
    digital_reset <= 1'b0;
    rchk("digital clear", PA, 32'h0);
    wait_ready();
    $display("test resets done");
    results();
  end
endmodule
